/* File: common/sar_seq_pkg.sv */
// sar_seq_pkg: constants, register map and carrier types of the sequencer
// assumes: 250 MHz system clock, registers reached over AXI4-Lite
package sar_seq_pkg;
    localparam int CLK_HZ          = 250_000_000;
    localparam int ADC_MAX_HZ      = 18_000_000;
    localparam int ADC_DIV         = (CLK_HZ + ADC_MAX_HZ - 1) / ADC_MAX_HZ;
    localparam int DIV_W           = 8;
    localparam int NUM_CH          = 8;
    localparam int CH_W            = 3;
    localparam int RES_W           = 12;
    localparam int ST_W            = 8;
    localparam int CNT_W           = 9;
    localparam int INT_W           = 16;
    localparam int CONV_MIN_CLKS   = 18;
    localparam int BIT_CLKS        = 12;
    localparam int FINISH_CLKS     = 1;
    localparam int MIN_SAMPLE_CLKS = CONV_MIN_CLKS - BIT_CLKS - FINISH_CLKS;
    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] CHEN_ADDR   = 8'h04;
    localparam logic [7:0] STAT_ADDR   = 8'h08;
    localparam logic [7:0] RANGE_ADDR  = 8'h0c;
    localparam logic [7:0] INTR_ADDR   = 8'h10;
    localparam logic [7:0] MASK_ADDR   = 8'h14;
    localparam logic [7:0] SAMPLE_BASE = 8'h20;
    localparam logic [7:0] RESULT_BASE = 8'h40;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_FW_BIT    = 1;
    localparam int CTRL_CONT_BIT  = 2;
    localparam int CTRL_START_BIT = 3;
    localparam int CTRL_CH_LSB    = 4;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_SLEEP_BIT = 1;
    localparam int STAT_CH_LSB    = 4;
    localparam int RANGE_HI_LSB   = 16;
    localparam int INT_DONE_BIT   = 0;
    localparam int INT_RANGE_BIT  = 1;
    localparam int INT_CH_LSB     = 8;
    localparam logic [RES_W-1:0]  RANGE_LO_RST = 12'h000;
    localparam logic [RES_W-1:0]  RANGE_HI_RST = 12'hfff;
    localparam logic [NUM_CH-1:0] CHEN_RST     = 8'hff;
    localparam logic [ST_W-1:0]   SAMPLE_RST   = 8'h00;
    localparam logic [RES_W-1:0]  DAC_MID      = 12'h800;
    localparam logic [1:0]        RESP_OKAY    = 2'h0;
    localparam logic [1:0]        RESP_SLVERR  = 2'h2;
    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'h0,
        SEQ_SAMPLE  = 2'h1,
        SEQ_CONVERT = 2'h3,
        SEQ_FINISH  = 2'h2
    } seq_state_type;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axi_m2s_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axi_s2m_type;

    typedef struct packed {
        logic [CH_W-1:0]  chan_sel;
        logic             sample_on;
        logic [RES_W-1:0] dac_code;
    } ana_out_type;
endpackage

/* File: verilog/pin_sync.sv */
// pin_sync: three-stage synchroniser for asynchronous level inputs
// assumes: inputs are slow levels; a change is taken once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 2
) (
    input  logic         aclk,
    input  logic         aresetn,
    input  logic [W-1:0] pin_in,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_type;

    sync_type s;
    sync_type n;

    always_comb begin
        n     = s;
        n.s1  = pin_in;
        n.s2  = s.s1;
        n.s3  = s.s2;
        // hold the old level while the last two stages disagree
        n.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 ^ s.s3));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign level = s.lvl;
endmodule

/* File: verilog/adc_clk_div.sv */
// adc_clk_div: one-cycle converter clock enable derived from aclk
// assumes: run low stops the enable (no high-speed clock in deep sleep)
`timescale 1ns/10ps
module adc_clk_div
    import sar_seq_pkg::*;
#(
    parameter logic [DIV_W-1:0] DIV = DIV_W'(ADC_DIV)
) (
    input  logic aclk,
    input  logic aresetn,
    input  logic run,
    output logic tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } div_type;

    div_type s;
    div_type n;

    always_comb begin
        n      = s;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = '0;
        end else if (s.cnt == DIV - 1'b1) begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule

/* File: verilog/sar_seq_core.sv */
// sar_seq_core: channel sequencer, SAR bit trials, window compare, registers
// assumes: comparator and sleep request are asynchronous pins; AXI4-Lite master
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module sar_seq_core
    import sar_seq_pkg::*;
#(
    parameter logic [DIV_W-1:0] ADC_CLK_DIV = DIV_W'(ADC_DIV)
) (
    input  logic        aclk,
    input  logic        aresetn,
    input  axi_m2s_type axi_i,
    output axi_s2m_type axi_o,
    input  logic        comp_hi,
    input  logic        deep_sleep,
    output ana_out_type ana_o,
    output logic        irq
);
    typedef struct packed {
        logic                            awready;
        logic                            wready;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            aw_have;
        logic                            w_have;
        logic [7:0]                      awaddr;
        logic [31:0]                     wdata;
        logic [3:0]                      wstrb;
        logic                            arready;
        logic                            rvalid;
        logic [1:0]                      rresp;
        logic [31:0]                     rdata;
        logic                            enable;
        logic                            fw_mode;
        logic                            cont;
        logic [CH_W-1:0]                 fw_ch;
        logic [NUM_CH-1:0]               chan_en;
        logic [RES_W-1:0]                range_lo;
        logic [RES_W-1:0]                range_hi;
        logic [INT_W-1:0]                intr;
        logic [INT_W-1:0]                mask;
        logic [NUM_CH-1:0][ST_W-1:0]     sample_time;
        logic [NUM_CH-1:0][RES_W-1:0]    result;
        seq_state_type                   seq;
        logic [CH_W-1:0]                 ch;
        logic [CNT_W-1:0]                cnt;
        logic [3:0]                      bit_idx;
        logic [RES_W-1:0]                dac;
        logic                            pend;
        logic                            asleep;
        logic                            busy;
        logic                            sample_on;
        logic                            irq;
    } core_type;

    core_type         s;
    core_type         n;
    logic [1:0]       sync_lvl;
    logic             comp_s;
    logic             sleep_s;
    logic             tick;

    ////////////////////////////////////////////////////////////////////////////////
    pin_sync #(
        .W (2)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  ({deep_sleep, comp_hi}),
        .level   (sync_lvl)
    );

    assign comp_s  = sync_lvl[0];
    assign sleep_s = sync_lvl[1];

    // the converter clock simply stops in deep sleep
    adc_clk_div #(
        .DIV (ADC_CLK_DIV)
    ) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (!sleep_s),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic core_type reset_state();
        core_type r;
        r          = '0;
        r.range_lo = RANGE_LO_RST;
        r.range_hi = RANGE_HI_RST;
        r.chan_en  = CHEN_RST;
        for (int i = 0; i < NUM_CH; i++) begin
            r.sample_time[i] = SAMPLE_RST;
        end
        return r;
    endfunction

    // returns {hit, data}
    function automatic logic [32:0] reg_read(core_type r, logic [7:0] a);
        logic [31:0] d;
        logic        hit;
        d   = '0;
        hit = 1'b1;
        if (a[7:5] == SAMPLE_BASE[7:5]) begin
            d[ST_W-1:0] = r.sample_time[a[4:2]];
        end else if (a[7:5] == RESULT_BASE[7:5]) begin
            d[RES_W-1:0] = r.result[a[4:2]];
        end else begin
            case ({a[7:2], 2'b00})
                CTRL_ADDR: begin
                    d[CTRL_EN_BIT]            = r.enable;
                    d[CTRL_FW_BIT]            = r.fw_mode;
                    d[CTRL_CONT_BIT]          = r.cont;
                    d[CTRL_CH_LSB +: CH_W]    = r.fw_ch;
                end
                CHEN_ADDR: d[NUM_CH-1:0] = r.chan_en;
                STAT_ADDR: begin
                    d[STAT_BUSY_BIT]          = r.busy;
                    d[STAT_SLEEP_BIT]         = r.asleep;
                    d[STAT_CH_LSB +: CH_W]    = r.ch;
                end
                RANGE_ADDR: begin
                    d[RES_W-1:0]              = r.range_lo;
                    d[RANGE_HI_LSB +: RES_W]  = r.range_hi;
                end
                INTR_ADDR: d[INT_W-1:0] = r.intr;
                MASK_ADDR: d[INT_W-1:0] = r.mask;
                default:   hit = 1'b0;
            endcase
        end
        return {hit, d};
    endfunction

    // {wrapped, channel}: next enabled channel above cur, else lowest enabled
    function automatic logic [CH_W:0] next_channel(logic [NUM_CH-1:0] en,
                                                   logic [CH_W-1:0] cur);
        logic [CH_W:0] r;
        r = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (en[i]) begin
                r[CH_W-1:0] = CH_W'(i);
            end
        end
        r[CH_W] = 1'b1;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (en[i] && (CH_W'(i) > cur)) begin
                r = {1'b0, CH_W'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] sample_load(logic [ST_W-1:0] st);
        return CNT_W'(st) + CNT_W'(MIN_SAMPLE_CLKS - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic [32:0]      rd_old;
    logic [32:0]      rd_ar;
    logic [31:0]      bmask;
    logic [31:0]      merged;
    logic             do_write;
    logic             start_wr;
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] int_clr;
    logic [CH_W:0]    nx;
    logic [CH_W-1:0]  nch;
    logic             wrap;

    always_comb begin
        n        = s;
        rd_old   = reg_read(s, s.awaddr);
        rd_ar    = reg_read(s, axi_i.araddr);
        bmask    = '0;
        start_wr = 1'b0;
        int_set  = '0;
        int_clr  = '0;
        nx       = '0;
        nch      = '0;
        wrap     = 1'b0;
        for (int i = 0; i < 4; i++) begin
            bmask[8*i +: 8] = {8{s.wstrb[i]}};
        end
        merged   = (rd_old[31:0] & ~bmask) | (s.wdata & bmask);
        do_write = s.aw_have && s.w_have && !s.bvalid;

        // write channel: address and data may come in either order
        if (axi_i.awvalid && s.awready) begin
            n.aw_have = 1'b1;
            n.awaddr  = axi_i.awaddr;
        end
        if (axi_i.wvalid && s.wready) begin
            n.w_have = 1'b1;
            n.wdata  = axi_i.wdata;
            n.wstrb  = axi_i.wstrb;
        end
        if (s.bvalid && axi_i.bready) begin
            n.bvalid = 1'b0;
        end
        if (do_write) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = rd_old[32] ? RESP_OKAY : RESP_SLVERR;
            if (s.awaddr[7:5] == SAMPLE_BASE[7:5]) begin
                n.sample_time[s.awaddr[4:2]] = merged[ST_W-1:0];
            end else begin
                case ({s.awaddr[7:2], 2'b00})
                    CTRL_ADDR: begin
                        n.enable  = merged[CTRL_EN_BIT];
                        n.fw_mode = merged[CTRL_FW_BIT];
                        n.cont    = merged[CTRL_CONT_BIT];
                        n.fw_ch   = merged[CTRL_CH_LSB +: CH_W];
                        start_wr  = s.wstrb[0] && s.wdata[CTRL_START_BIT];
                    end
                    CHEN_ADDR:  n.chan_en = merged[NUM_CH-1:0];
                    RANGE_ADDR: begin
                        n.range_lo = merged[RES_W-1:0];
                        n.range_hi = merged[RANGE_HI_LSB +: RES_W];
                    end
                    INTR_ADDR:  int_clr = s.wdata[INT_W-1:0] & bmask[INT_W-1:0];
                    MASK_ADDR:  n.mask = merged[INT_W-1:0];
                    default:    n.mask = s.mask;
                endcase
            end
        end
        n.awready = !n.aw_have;
        n.wready  = !n.w_have;

        // read channel: data captured at the address handshake
        if (s.rvalid && axi_i.rready) begin
            n.rvalid = 1'b0;
        end
        if (axi_i.arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_ar[31:0];
            n.rresp  = rd_ar[32] ? RESP_OKAY : RESP_SLVERR;
        end
        n.arready = !n.rvalid;

        ////////////////////////////////////////////////////////////////////////
        // sequencer; one step per converter clock enable
        n.asleep = sleep_s;
        if (sleep_s) begin
            n.seq  = SEQ_IDLE;
            n.pend = 1'b0;
        end else if (tick) begin
            case (s.seq)
                SEQ_IDLE: begin
                    nx  = next_channel(s.chan_en, {CH_W{1'b1}});
                    nch = s.fw_mode ? s.fw_ch : nx[CH_W-1:0];
                    if (s.enable && s.pend && (s.fw_mode || (|s.chan_en))) begin
                        n.pend = 1'b0;
                        n.seq  = SEQ_SAMPLE;
                        n.ch   = nch;
                        n.cnt  = sample_load(s.sample_time[nch]);
                    end
                end
                SEQ_SAMPLE: begin
                    // acquisition stretches with the channel's own setting
                    if (s.cnt == '0) begin
                        n.seq     = SEQ_CONVERT;
                        n.dac     = DAC_MID;
                        n.bit_idx = 4'(RES_W - 1);
                    end else begin
                        n.cnt = s.cnt - 1'b1;
                    end
                end
                SEQ_CONVERT: begin
                    // comparator high means the input sits above the trial code
                    if (!comp_s) begin
                        n.dac[s.bit_idx] = 1'b0;
                    end
                    if (s.bit_idx == 4'h0) begin
                        n.seq = SEQ_FINISH;
                    end else begin
                        n.dac[s.bit_idx - 1'b1] = 1'b1;
                        n.bit_idx               = s.bit_idx - 1'b1;
                    end
                end
                SEQ_FINISH: begin
                    n.result[s.ch] = s.dac;
                    if ((s.dac < s.range_lo) || (s.dac > s.range_hi)) begin
                        int_set[INT_RANGE_BIT]             = 1'b1;
                        int_set[INT_CH_LSB + int'(s.ch)]   = 1'b1;
                    end
                    nx = next_channel(s.chan_en, s.ch);
                    if (s.fw_mode) begin
                        wrap = 1'b1;
                        nch  = s.fw_ch;
                    end else begin
                        wrap = nx[CH_W];
                        nch  = nx[CH_W-1:0];
                    end
                    int_set[INT_DONE_BIT] = wrap;
                    // next sample starts right away: no gap between channels
                    if (!s.enable || (!s.fw_mode && !(|s.chan_en)) ||
                        (wrap && !s.cont)) begin
                        n.seq = SEQ_IDLE;
                    end else begin
                        n.seq = SEQ_SAMPLE;
                        n.ch  = nch;
                        n.cnt = sample_load(s.sample_time[nch]);
                    end
                end
                default: n.seq = SEQ_IDLE;
            endcase
        end
        // a start written during a conversion waits for the idle state
        if (start_wr && !sleep_s) begin
            n.pend = 1'b1;
        end

        // hardware set wins over a same-cycle software clear
        n.intr      = (s.intr & ~int_clr) | int_set;
        n.irq       = |(n.intr & n.mask);
        n.busy      = (n.seq != SEQ_IDLE);
        n.sample_on = (n.seq == SEQ_SAMPLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= reset_state();
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign axi_o.awready   = s.awready;
    assign axi_o.wready    = s.wready;
    assign axi_o.bresp     = s.bresp;
    assign axi_o.bvalid    = s.bvalid;
    assign axi_o.arready   = s.arready;
    assign axi_o.rdata     = s.rdata;
    assign axi_o.rresp     = s.rresp;
    assign axi_o.rvalid    = s.rvalid;
    assign ana_o.chan_sel  = s.ch;
    assign ana_o.sample_on = s.sample_on;
    assign ana_o.dac_code  = s.dac;
    assign irq             = s.irq;
endmodule

/* File: test/sar_seq_checker.sv */
// sar_seq_checker: port-level properties of the sequencer core
// assumes: bound to sar_seq_core; one aclk domain, sync active-low reset
`timescale 1ns/10ps
module sar_seq_checker
    import sar_seq_pkg::*;
#(
    parameter logic [DIV_W-1:0] ADC_CLK_DIV = DIV_W'(ADC_DIV)
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire axi_m2s_type axi_i,
    input wire axi_s2m_type axi_o,
    input wire logic        comp_hi,
    input wire logic        deep_sleep,
    input wire ana_out_type ana_o,
    input wire logic        irq
);
    logic [9:0] gap;

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////
    // cycles since the last acquisition began; saturates so idle spans never wrap
    always_ff @(posedge aclk) begin
        if (!aresetn)
            gap <= 10'h000;
        else if ($rose(ana_o.sample_on))
            gap <= 10'h001;
        else if (gap != 10'h000 && gap != 10'h3ff)
            gap <= gap + 10'h001;
    end

    sequence s_wr_taken;
        axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready;
    endsequence
    sequence s_rd_taken;
        axi_i.arvalid && axi_o.arready;
    endsequence

    property p_bhold;
        axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid && $stable(axi_o.bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        axi_o.rvalid && !axi_i.rready |=> axi_o.rvalid && $stable(axi_o.rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rans;
        s_rd_taken |=> axi_o.rvalid && !axi_o.arready;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bans;
        s_wr_taken |-> ##[1:2] axi_o.bvalid;
    endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_slverr;
        s_rd_taken ##0 axi_i.araddr == 8'h18 |=> axi_o.rresp == RESP_SLVERR;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read accepted");
    // a sleep abort may cut acquisition short, so only awake ends are judged
    property p_smin;
        $fell(ana_o.sample_on) && !deep_sleep |-> $past(ana_o.sample_on, 8);
    endproperty
    a_smin: assert property (p_smin) else $error("acquisition too short");
    property p_conv;
        $rose(ana_o.sample_on) && gap != 10'h000 |-> gap >= CONV_MIN_CLKS * ADC_CLK_DIV;
    endproperty
    a_conv: assert property (p_conv) else $error("conversion too short");
    property p_sleep;
        deep_sleep [*7] |-> !ana_o.sample_on;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sampling in sleep");
endmodule

bind sar_seq_core sar_seq_checker #(.ADC_CLK_DIV(ADC_CLK_DIV)) chk_u (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .axi_i      (axi_i),
    .axi_o      (axi_o),
    .comp_hi    (comp_hi),
    .deep_sleep (deep_sleep),
    .ana_o      (ana_o),
    .irq        (irq)
);

/* File: test/sar_analog_model.sv */
// sar_analog_model: eight channel inputs, sample-and-hold and comparator
// assumes: driven by the core's analog outputs; comp_hi is resynchronised there
`timescale 1ns/10ps
module sar_analog_model
    import sar_seq_pkg::*;
(
    input wire logic             aclk,
    input wire ana_out_type      ana_i,
    input wire logic [RES_W-1:0] vin [NUM_CH],
    output logic                 comp_hi
);
    logic [RES_W-1:0] held = 12'h000;

    ////////////////////////////////////////
    always @(posedge aclk) begin
        if (ana_i.sample_on === 1'b1)
            held <= vin[ana_i.chan_sel];
        // input sits half a step above its code, so a trial equal to it keeps the bit
        comp_hi <= (held >= ana_i.dac_code);
    end
endmodule

/* File: test/tb_top.sv */
// tb_top: register-level tests of the sequencer core beside an analog model
// assumes: this bench is the AXI4-Lite master; converter divider cut to 8
`timescale 1ns/10ps
module tb_top
    import sar_seq_pkg::*;
;
    // comparator reaches the core through the model's flop and a four-flop sync,
    // five cycles, so a divider below six would judge each bit on a stale compare
    localparam logic [DIV_W-1:0] DIV = 8'h08;
    localparam logic [7:0]       EN  = 8'ha5;
    logic             aclk;
    logic             aresetn;
    logic             deep_sleep;
    logic             comp_hi;
    logic             irq;
    axi_m2s_type      m;
    axi_s2m_type      s;
    ana_out_type      ana;
    logic [RES_W-1:0] vin [NUM_CH];
    logic [31:0]      d;
    logic [1:0]       r;
    int               mismatches;
    int               num_checks;
    int               hi_run;
    int               lo_run;

    sar_seq_core #(.ADC_CLK_DIV(DIV)) dut_u (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .axi_i      (m),
        .axi_o      (s),
        .comp_hi    (comp_hi),
        .deep_sleep (deep_sleep),
        .ana_o      (ana),
        .irq        (irq)
    );
    sar_analog_model ana_u (
        .aclk    (aclk),
        .ana_i   (ana),
        .vin     (vin),
        .comp_hi (comp_hi)
    );

    always #2 aclk = ~aclk;

    ////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        m.awaddr <= a;
        m.awvalid <= 1'b1;
        m.wdata <= v;
        m.wstrb <= 4'hf;
        m.wvalid <= 1'b1;
        m.bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (s.awready !== 1'b1);
                m.awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (s.wready !== 1'b1);
                m.wvalid <= 1'b0;
            end
        join
        while (s.bvalid !== 1'b1)
            @(posedge aclk);
        check("bresp", s.bresp, er);
        m.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        m.araddr <= a;
        m.arvalid <= 1'b1;
        m.rready <= 1'b1;
        do @(posedge aclk); while (s.arready !== 1'b1);
        m.arvalid <= 1'b0;
        do @(posedge aclk); while (s.rvalid !== 1'b1);
        d = s.rdata;
        r = s.rresp;
        m.rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check($sformatf("reg %h", a), d, e);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge aclk);
        check("irq", irq, e);
    endtask
    task automatic wait_done;
        d = 32'h0000_0000;
        while (d[INT_DONE_BIT] !== 1'b1)
            rd(INTR_ADDR);
    endtask

    // sample time of channel i is i, so every run length is known in advance
    always @(posedge aclk) begin
        if (ana.sample_on === 1'b1) begin
            if (lo_run > 0 && lo_run < (BIT_CLKS + FINISH_CLKS + 1) * DIV)
                check("gap", lo_run, (BIT_CLKS + FINISH_CLKS) * DIV);
            lo_run = 0;
            hi_run++;
        end else begin
            if (hi_run > 0 && !deep_sleep)
                check("sample", hi_run, (ana.chan_sel + 5) * DIV);
            hi_run = 0;
            lo_run++;
        end
    end

    initial begin
        repeat (10000) @(posedge aclk);
        mismatches++;
        end_sim;
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        deep_sleep = 1'b0;
        m = '0;
        vin = '{12'h050, 12'h111, 12'h800, 12'h222, 12'h333, 12'hf00, 12'h444, 12'h100};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(CTRL_ADDR, 32'h0000_0000);
        rchk(CHEN_ADDR, 32'h0000_00ff);
        rchk(RANGE_ADDR, 32'h0fff_0000);
        rchk(INTR_ADDR, 32'h0000_0000);
        rchk(MASK_ADDR, 32'h0000_0000);
        for (int i = 0; i < NUM_CH; i++) begin
            rchk(SAMPLE_BASE + 8'(4 * i), 32'h0000_0000);
            rchk(RESULT_BASE + 8'(4 * i), 32'h0000_0000);
            wr(SAMPLE_BASE + 8'(4 * i), 32'(i), RESP_OKAY);
        end
        rd(8'h18);
        check("rresp", r, RESP_SLVERR);
        wr(8'h18, 32'h0000_0001, RESP_SLVERR);
        wr(CHEN_ADDR, {24'h00_0000, EN}, RESP_OKAY);
        wr(RANGE_ADDR, 32'h0e00_0100, RESP_OKAY);
        wr(MASK_ADDR, 32'h0000_0002, RESP_OKAY);
        wr(CTRL_ADDR, 32'h0000_0009, RESP_OKAY);
        while (irq !== 1'b1)
            @(posedge aclk);
        rchk(INTR_ADDR, 32'h0000_0102);
        wait_done;
        rchk(INTR_ADDR, 32'h0000_2103);
        for (int i = 0; i < NUM_CH; i++)
            rchk(RESULT_BASE + 8'(4 * i), 32'(vin[i]) & {32{EN[i]}});
        wr(MASK_ADDR, 32'h0000_0000, RESP_OKAY);
        irq_is(1'b0);
        wr(MASK_ADDR, 32'h0000_ff03, RESP_OKAY);
        irq_is(1'b1);
        wr(INTR_ADDR, 32'h0000_2103, RESP_OKAY);
        rchk(INTR_ADDR, 32'h0000_0000);
        irq_is(1'b0);
        wr(CTRL_ADDR, 32'h0000_006b, RESP_OKAY);
        wait_done;
        rchk(RESULT_BASE + 8'h18, 32'h0000_0444);
        rchk(INTR_ADDR, 32'h0000_0001);
        wr(INTR_ADDR, 32'h0000_0001, RESP_OKAY);
        wr(CTRL_ADDR, 32'h0000_000d, RESP_OKAY);
        repeat (50) @(posedge aclk);
        deep_sleep <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(STAT_ADDR);
        check("status", d & 32'h0000_0003, 32'h0000_0002);
        wr(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
        deep_sleep <= 1'b0;
        repeat (40) @(posedge aclk);
        check("sample_on", ana.sample_on, 1'b0);
        end_sim;
    end
endmodule
